/* File: hw/dof_defines.vh */
`ifndef DOF_DEFINES_VH
`define DOF_DEFINES_VH
// command frame
`define DOF_CMD_BITS    40
`define DOF_ADDR_HI     39
`define DOF_ADDR_LO     37
`define DOF_UPDATE      36
`define DOF_ADDR_W3     3'h3
`define DOF_ADDR_W4     3'h4
`define DOF_ADDR_W5     3'h5
`define DOF_ADDR_W6     3'h6
// word three
`define DOF_W3_SLEN_HI  31
`define DOF_W3_SLEN_LO  18
`define DOF_W3_POFF_HI  17
`define DOF_W3_RST      36'h000000000
// word four
`define DOF_W4_UPCONV   32
`define DOF_W4_REAL     31
`define DOF_W4_DPH_HI   30
`define DOF_W4_DPH_LO   7
`define DOF_W4_SHF_HI   6
`define DOF_W4_SHF_LO   1
`define DOF_W4_SPREV    0
`define DOF_W4_RST      36'h000000000
// word five
`define DOF_W5_PRE_HI   35
`define DOF_W5_PRE_LO   21
`define DOF_W5_GAIN_HI  20
`define DOF_W5_GAIN_LO  5
`define DOF_W5_FMT_HI   4
`define DOF_W5_FMT_LO   3
`define DOF_W5_WID_HI   2
`define DOF_W5_WID_LO   1
`define DOF_W5_MSBF     0
`define DOF_W5_RST      36'h000100000
// word six
`define DOF_W6_IQ       35
`define DOF_W6_SLOT_HI  34
`define DOF_W6_SLOT_LO  29
`define DOF_W6_CKPOL    28
`define DOF_W6_DUTY     27
`define DOF_W6_CONT     26
`define DOF_W6_CKTS_HI  25
`define DOF_W6_CKTS_LO  24
`define DOF_W6_STPOL    23
`define DOF_W6_STLOC    22
`define DOF_W6_STTS_HI  21
`define DOF_W6_STTS_LO  20
`define DOF_W6_IPOL     19
`define DOF_W6_ITS_HI   18
`define DOF_W6_ITS_LO   17
`define DOF_W6_QPOL     16
`define DOF_W6_QTS_HI   15
`define DOF_W6_QTS_LO   14
`define DOF_W6_INTWOS   13
`define DOF_W6_RATE_HI  12
`define DOF_W6_RATE_LO  0
`define DOF_W6_RST      36'h000000000
// codes
`define DOF_TS_ENABLE   2'h1
`define DOF_FMT_TWOS    2'h0
`define DOF_WORD_BITS   16
`endif

/* File: hw/dof_formatter.v */
`include "dof_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module dof_formatter #(
	parameter DATA_W = 16
) (
	input  wire              sys_clk,
	input  wire              resetn,
	input  wire              cmdClk,
	input  wire              cmdData,
	input  wire              cmdSelN,
	input  wire              sampleValid,
	input  wire [DATA_W-1:0] sampleI,
	input  wire [DATA_W-1:0] sampleQ,
	output wire              sampleReady,
	output wire              bitClkOut,
	output wire              bitClkOe,
	output wire              wordStrobeOut,
	output wire              wordStrobeOe,
	output wire              iOut,
	output wire              iOe,
	output wire              qOut,
	output wire              qOe,
	output wire [17:0]       phaseOffset,
	output wire [13:0]       slotLength,
	output wire [23:0]       deltaPhase,
	output wire [5:0]        hdsShift,
	output wire              sineNegate,
	output wire [14:0]       hdsPreload,
	output wire              inputTwosComp
);
	localparam ST_IDLE  = 2'h0;
	localparam ST_WAIT  = 2'h1;
	localparam ST_LEAD  = 2'h2;
	localparam ST_SHIFT = 2'h3;
	localparam [5:0] LAST_ONE = 6'd15;
	localparam [5:0] LAST_TWO = 6'd31;

	// most negative value clips to most positive
	function [15:0] negSat;
		input [15:0] v;
		begin
			negSat = (v == 16'h8000) ? 16'h7fff : (~v + 16'h0001);
		end
	endfunction

	// product shifted back by fifteen, clipped to sixteen bits
	function [15:0] scaleSat;
		input [15:0] s;
		input [15:0] g;
		reg signed [32:0] p;
		reg signed [32:0] sh;
		begin
			p = $signed({{17{s[15]}}, s}) * $signed({17'h00000, g});
			sh = p >>> 15;
			if (sh[32:15] != {18{sh[15]}})
				scaleSat = sh[32] ? 16'h8000 : 16'h7fff;
			else
				scaleSat = sh[15:0];
		end
	endfunction

	// lsb-first bit order
	function [15:0] rev16;
		input [15:0] v;
		integer k;
		begin
			for (k = 0; k < 16; k = k + 1) begin
				rev16[k] = v[15-k];
			end
		end
	endfunction

	// three-state code that turns a pin driver on
	function tsOn;
		input [1:0] code;
		begin
			tsOn = code == `DOF_TS_ENABLE;
		end
	endfunction

	// command port synchronisers
	reg        cmdClkS1_q;
	reg        cmdClkS2_q;
	reg        cmdClkS3_q;
	reg        cmdDataS1_q;
	reg        cmdDataS2_q;
	reg        cmdSelNS1_q;
	reg        cmdSelNS2_q;
	reg [38:0] cmdShift_q;
	reg [5:0]  cmdCnt_q;
	reg [35:0] w3_q;
	reg [35:0] w4_q;
	reg [35:0] w5_q;
	reg [35:0] w6_q;
	// edge seen at the same stage as data, so data must settle before the clock rises
	wire       cmdRise = cmdClkS2_q & ~cmdClkS3_q;
	wire [39:0] cmdWord = {cmdShift_q, cmdDataS2_q};
	wire       cmdDone = cmdRise & ~cmdSelNS2_q && (cmdCnt_q == 6'd39);
	wire [2:0] cmdAddr = cmdWord[`DOF_ADDR_HI:`DOF_ADDR_LO];

	always @(posedge sys_clk) begin
		if (!resetn) begin
			cmdClkS1_q  <= 1'b0;
			cmdClkS2_q  <= 1'b0;
			cmdClkS3_q  <= 1'b0;
			cmdDataS1_q <= 1'b0;
			cmdDataS2_q <= 1'b0;
			cmdSelNS1_q <= 1'b1;
			cmdSelNS2_q <= 1'b1;
			cmdShift_q  <= 39'h0;
			cmdCnt_q    <= 6'h0;
			w3_q        <= `DOF_W3_RST;
			w4_q        <= `DOF_W4_RST;
			w5_q        <= `DOF_W5_RST;
			w6_q        <= `DOF_W6_RST;
		end else begin
			cmdClkS1_q  <= cmdClk;
			cmdClkS2_q  <= cmdClkS1_q;
			cmdClkS3_q  <= cmdClkS2_q;
			cmdDataS1_q <= cmdData;
			cmdDataS2_q <= cmdDataS1_q;
			cmdSelNS1_q <= cmdSelN;
			cmdSelNS2_q <= cmdSelNS1_q;
			if (cmdSelNS2_q) begin
				cmdCnt_q <= 6'h0;
			end else if (cmdRise) begin
				cmdShift_q <= cmdWord[38:0];
				cmdCnt_q   <= cmdDone ? 6'h0 : cmdCnt_q + 6'h01;
			end
			if (cmdDone && cmdWord[`DOF_UPDATE]) begin
				case (cmdAddr)
				`DOF_ADDR_W3: w3_q <= cmdWord[35:0];
				`DOF_ADDR_W4: w4_q <= cmdWord[35:0];
				`DOF_ADDR_W5: w5_q <= cmdWord[35:0];
				`DOF_ADDR_W6: w6_q <= cmdWord[35:0];
				default: w3_q <= w3_q;
				endcase
			end
		end
	end

	assign phaseOffset   = w3_q[`DOF_W3_POFF_HI:0];
	assign slotLength    = w3_q[`DOF_W3_SLEN_HI:`DOF_W3_SLEN_LO];
	assign deltaPhase    = w4_q[`DOF_W4_DPH_HI:`DOF_W4_DPH_LO];
	assign hdsShift      = w4_q[`DOF_W4_SHF_HI:`DOF_W4_SHF_LO];
	assign sineNegate    = w4_q[`DOF_W4_SPREV];
	assign hdsPreload    = w5_q[`DOF_W5_PRE_HI:`DOF_W5_PRE_LO];
	assign inputTwosComp = w6_q[`DOF_W6_INTWOS];

	wire        upConv   = w4_q[`DOF_W4_UPCONV];
	wire        realMode = w4_q[`DOF_W4_REAL];
	wire [15:0] gain     = w5_q[`DOF_W5_GAIN_HI:`DOF_W5_GAIN_LO];
	wire        fmtOff   = w5_q[`DOF_W5_FMT_HI:`DOF_W5_FMT_LO] != `DOF_FMT_TWOS;
	wire        msbFirst = w5_q[`DOF_W5_MSBF];
	wire        iqOnI    = w6_q[`DOF_W6_IQ];
	wire [5:0]  slotNum  = w6_q[`DOF_W6_SLOT_HI:`DOF_W6_SLOT_LO];
	wire        ckPol    = w6_q[`DOF_W6_CKPOL];
	wire        duty50   = w6_q[`DOF_W6_DUTY];
	wire        ckCont   = w6_q[`DOF_W6_CONT];
	wire        stPol    = w6_q[`DOF_W6_STPOL];
	wire        stAfter  = w6_q[`DOF_W6_STLOC];
	wire        iPol     = w6_q[`DOF_W6_IPOL];
	wire        qPol     = w6_q[`DOF_W6_QPOL];
	wire [12:0] rate     = w6_q[`DOF_W6_RATE_HI:`DOF_W6_RATE_LO];

	// two-entry sample buffer
	reg [2*DATA_W-1:0] bufMem_q [0:1];
	reg                bufWr_q;
	reg                bufRd_q;
	reg [1:0]          bufCnt_q;
	reg                inReady_q;
	wire               bufPush = sampleValid & inReady_q;
	wire               bufValid = bufCnt_q != 2'h0;
	wire               bufPop;
	wire [1:0]         bufCntD = bufCnt_q + {1'b0, bufPush} - {1'b0, bufPop};
	wire [2*DATA_W-1:0] bufHead = bufMem_q[bufRd_q];

	always @(posedge sys_clk) begin
		if (!resetn) begin
			bufWr_q   <= 1'b0;
			bufRd_q   <= 1'b0;
			bufCnt_q  <= 2'h0;
			inReady_q <= 1'b0;
		end else begin
			if (bufPush) begin
				bufMem_q[bufWr_q] <= {sampleI, sampleQ};
				bufWr_q <= ~bufWr_q;
			end
			if (bufPop)
				bufRd_q <= ~bufRd_q;
			bufCnt_q  <= bufCntD;
			// ready taken from the next count so a full buffer stalls in time
			inReady_q <= bufCntD != 2'h2;
		end
	end
	assign sampleReady = inReady_q;

	// sample datapath
	reg         hsPhase_q;
	reg [1:0]   rlPhase_q;
	wire [15:0] hI = bufHead[2*DATA_W-1 -: 16] ^ {~inputTwosComp, 15'h0};
	wire [15:0] hQ = bufHead[DATA_W-1 -: 16] ^ {~inputTwosComp, 15'h0};
	wire [15:0] sI = scaleSat(hI, gain);
	wire [15:0] sQ = scaleSat(hQ, gain);
	wire        flip = upConv & hsPhase_q;
	wire [15:0] uI = flip ? negSat(sI) : sI;
	wire [15:0] uQ = flip ? negSat(sQ) : sQ;
	reg  [15:0] rv;

	always @* begin
		case (rlPhase_q)
		2'h0: rv = uI;
		2'h1: rv = negSat(uQ);
		2'h2: rv = negSat(uI);
		default: rv = uQ;
		endcase
	end

	wire [15:0] fI = (realMode ? rv : uI) ^ {fmtOff, 15'h0};
	wire [15:0] fQ = uQ ^ {fmtOff, 15'h0};
	wire [15:0] oI = msbFirst ? fI : rev16(fI);
	wire [15:0] oQ = msbFirst ? fQ : rev16(fQ);
	wire        twoWords = iqOnI & ~realMode;

	// bit clock divider
	// one bit period is rate plus one cycles
	reg  [12:0] divCnt_q;
	wire        bitEnd = divCnt_q == rate;
	wire [12:0] half = (rate + 13'h0001) >> 1;
	wire        rawClk = duty50 ? (divCnt_q >= half) : (divCnt_q == half);

	// serializer
	reg [1:0]  state_q;
	reg [31:0] shI_q;
	reg [15:0] shQ_q;
	reg [5:0]  bitCnt_q;
	reg [5:0]  lastBit_q;
	reg [9:0]  waitCnt_q;
	reg        firstBit_q;
	reg        bitClk_q;
	reg        bitClkOe_q;
	reg        strobe_q;
	reg        strobeOe_q;
	reg        iOut_q;
	reg        iOe_q;
	reg        qOut_q;
	reg        qOe_q;
	wire       sending = (state_q == ST_SHIFT) | (state_q == ST_LEAD);
	assign bufPop = bitEnd && (state_q == ST_IDLE) && bufValid;

	always @(posedge sys_clk) begin
		if (!resetn) begin
			divCnt_q   <= 13'h0;
			state_q    <= ST_IDLE;
			shI_q      <= 32'h0;
			shQ_q      <= 16'h0;
			bitCnt_q   <= 6'h0;
			lastBit_q  <= 6'h0;
			waitCnt_q  <= 10'h0;
			firstBit_q <= 1'b0;
			hsPhase_q  <= 1'b0;
			rlPhase_q  <= 2'h0;
		end else begin
			divCnt_q <= bitEnd ? 13'h0 : divCnt_q + 13'h0001;
			if (bitEnd) begin
				case (state_q)
				ST_IDLE: begin
					if (bufValid) begin
						shI_q      <= twoWords ? {oI, oQ} : {oI, 16'h0};
						shQ_q      <= oQ;
						lastBit_q  <= twoWords ? LAST_TWO : LAST_ONE;
						bitCnt_q   <= 6'h0;
						firstBit_q <= 1'b1;
						hsPhase_q  <= ~hsPhase_q;
						// real phase advances once per popped sample
						rlPhase_q  <= rlPhase_q + 2'h1;
						// sixteen bit periods per slot before the word
						waitCnt_q  <= {slotNum, 4'h0};
						if (slotNum != 6'h0)
							state_q <= ST_WAIT;
						else
							state_q <= stAfter ? ST_SHIFT : ST_LEAD;
					end
				end
				ST_WAIT: begin
					waitCnt_q <= waitCnt_q - 10'h001;
					if (waitCnt_q == 10'h001)
						state_q <= stAfter ? ST_SHIFT : ST_LEAD;
				end
				ST_LEAD: begin
					state_q <= ST_SHIFT;
				end
				ST_SHIFT: begin
					firstBit_q <= 1'b0;
					shI_q      <= {shI_q[30:0], 1'b0};
					shQ_q      <= {shQ_q[14:0], 1'b0};
					bitCnt_q   <= bitCnt_q + 6'h01;
					if (bitCnt_q == lastBit_q)
						state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// next pin values, one cycle behind the serializer state
	wire bitClk_d   = ((ckCont | sending) & rawClk) ^ ckPol;
	wire bitClkOe_d = tsOn(w6_q[`DOF_W6_CKTS_HI:`DOF_W6_CKTS_LO]);
	wire strobe_d   = ((state_q == ST_LEAD) | ((state_q == ST_SHIFT) & firstBit_q & stAfter)) ^ stPol;
	wire strobeOe_d = tsOn(w6_q[`DOF_W6_STTS_HI:`DOF_W6_STTS_LO]);
	wire iOut_d     = ((state_q == ST_SHIFT) & shI_q[31]) ^ iPol;
	wire iOe_d      = tsOn(w6_q[`DOF_W6_ITS_HI:`DOF_W6_ITS_LO]);
	wire qOut_d     = ((state_q == ST_SHIFT) & ~twoWords & ~realMode & shQ_q[15]) ^ qPol;
	wire qOe_d      = tsOn(w6_q[`DOF_W6_QTS_HI:`DOF_W6_QTS_LO]);

	// pin stage
	always @(posedge sys_clk) begin
		if (!resetn) begin
			bitClk_q   <= 1'b0;
			bitClkOe_q <= 1'b0;
			strobe_q   <= 1'b0;
			strobeOe_q <= 1'b0;
			iOut_q     <= 1'b0;
			iOe_q      <= 1'b0;
			qOut_q     <= 1'b0;
			qOe_q      <= 1'b0;
		end else begin
			bitClk_q   <= bitClk_d;
			bitClkOe_q <= bitClkOe_d;
			strobe_q   <= strobe_d;
			strobeOe_q <= strobeOe_d;
			iOut_q     <= iOut_d;
			iOe_q      <= iOe_d;
			qOut_q     <= qOut_d;
			qOe_q      <= qOe_d;
		end
	end

	assign bitClkOut     = bitClk_q;
	assign bitClkOe      = bitClkOe_q;
	assign wordStrobeOut = strobe_q;
	assign wordStrobeOe  = strobeOe_q;
	assign iOut          = iOut_q;
	assign iOe           = iOe_q;
	assign qOut          = qOut_q;
	assign qOe           = qOe_q;
endmodule
`default_nettype wire

/* File: bench/dof_formatter_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module dof_formatter_sva (
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic        cmdSelN,
	input wire logic        sampleValid,
	input wire logic        sampleReady,
	input wire logic        bitClkOut,
	input wire logic        bitClkOe,
	input wire logic        wordStrobeOut,
	input wire logic        wordStrobeOe,
	input wire logic        iOut,
	input wire logic        iOe,
	input wire logic        qOe,
	input wire logic [23:0] deltaPhase,
	input wire logic [5:0]  hdsShift,
	input wire logic [14:0] hdsPreload
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence strobeLead;
		$rose(wordStrobeOut) ##1 wordStrobeOut;
	endsequence
	sequence dataRun;
		!wordStrobeOut [*8];
	endsequence
	reset_quiet_a: assert property ($rose(resetn) |-> !(iOe || qOe || bitClkOe || wordStrobeOe || sampleReady))
		else $error("outputs active right after reset");
	ready_after_reset_a: assert property ($rose(resetn) |=> sampleReady)
		else $error("sample ready late after reset");
	ready_holds_a: assert property (sampleReady && !sampleValid |=> sampleReady)
		else $error("sample ready dropped without a push");
	config_quiet_a: assert property (cmdSelN [*8] |-> $stable({deltaPhase, hdsShift, hdsPreload}))
		else $error("config changed while deselected");
	bit_stable_a: assert property ($rose(bitClkOut) |-> $stable(iOut))
		else $error("data moved at bit clock rise");
	strobe_lead_a: assert property (strobeLead |-> ##[1:8] $rose(bitClkOut))
		else $error("no bit clock after strobe");
	strobe_width_a: assert property ($rose(wordStrobeOut) |-> wordStrobeOut [*2] ##1 !wordStrobeOut)
		else $error("strobe not one bit period");
	word_run_a: assert property ($fell(wordStrobeOut) |-> dataRun)
		else $error("strobe too soon after word start");
endmodule
bind dof_formatter dof_formatter_sva u_sva (.sys_clk, .resetn, .cmdSelN, .sampleValid, .sampleReady, .bitClkOut,
	.bitClkOe, .wordStrobeOut, .wordStrobeOe, .iOut, .iOe, .qOe, .deltaPhase, .hdsShift, .hdsPreload);
`default_nettype wire

/* File: bench/dof_port_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dof_port_model (
	input wire logic       sys_clk,
	input wire logic       bitClkOut,
	input wire logic       wordStrobeOut,
	input wire logic       iOut,
	input wire logic [1:0] perStrobe
);
	logic [15:0] words[$];
	logic [15:0] sh;
	logic        clkPrev;
	int          bits = 99;
	always @(posedge sys_clk) begin
		clkPrev <= bitClkOut;
		if (bitClkOut && !clkPrev) begin
			if (wordStrobeOut) bits = 0;
			else if (bits < 16 * perStrobe) begin
				sh = {sh[14:0], iOut};
				bits++;
				if (bits % 16 == 0) words.push_back(sh);
			end
		end
	end
endmodule
`default_nettype wire

/* File: bench/dof_formatter_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dof_formatter_test;
	logic        sys_clk, resetn, cmdClk, cmdData, cmdSelN, sampleValid;
	logic [15:0] sampleI, sampleQ;
	logic [1:0]  mode;
	wire         sampleReady, bitClkOut, bitClkOe, wordStrobeOut, wordStrobeOe, iOut, iOe, qOut, qOe;
	wire         sineNegate, inputTwosComp;
	wire  [17:0] phaseOffset;
	wire  [13:0] slotLength;
	wire  [23:0] deltaPhase;
	wire  [5:0]  hdsShift;
	wire  [14:0] hdsPreload;
	int          mismatches = 0, total_checks = 0, cycles = 0, m, k, t;
	int unsigned seed = 14781;
	logic [15:0] exp[$];
	logic [31:0] a, b, dph;
	dof_formatter DUT (.sys_clk, .resetn, .cmdClk, .cmdData, .cmdSelN, .sampleValid, .sampleI, .sampleQ,
		.sampleReady, .bitClkOut, .bitClkOe, .wordStrobeOut, .wordStrobeOe, .iOut, .iOe, .qOut, .qOe,
		.phaseOffset, .slotLength, .deltaPhase, .hdsShift, .sineNegate, .hdsPreload, .inputTwosComp);
	dof_port_model rx (.sys_clk, .bitClkOut, .wordStrobeOut, .iOut, .perStrobe(mode == 2'h2 ? 2'h1 : 2'h2));
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] ng(input logic [15:0] x);
		return x == 16'h8000 ? 16'h7fff : 16'h0 - x;
	endfunction
	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		total_checks++;
		if (seen !== want) begin
			mismatches++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, want);
		end
	endtask
	task automatic send(input logic [39:0] w);
		cmdSelN = 0;
		for (int i = 39; i >= 0; i--) begin
			cmdData = w[i];
			#100 cmdClk = 1;
			#100 cmdClk = 0;
		end
		repeat (8) @(posedge sys_clk);
		#1 cmdSelN = 1;
		repeat (10) @(posedge sys_clk);
		#1;
	endtask
	task automatic push(input logic [15:0] x, y);
		sampleI = x;
		sampleQ = y;
		sampleValid = 1;
		for (int i = 0; i < 500 && sampleReady !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
		end
		@(posedge sys_clk);
		#1;
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		{sys_clk, resetn, cmdClk, cmdData, sampleValid, sampleI, sampleQ, mode} = 0;
		cmdSelN = 1;
		for (m = 0; m < 3; m++) begin
			mode = m[1:0];
			repeat (3) @(posedge sys_clk);
			#1 resetn = 0;
			repeat (3) @(posedge sys_clk);
			#1 resetn = 1;
			if (m == 0) begin
				check({slotLength, hdsPreload, hdsShift}, 0);
				send({3'h3, 1'b0, 4'h0, 14'h2a5c, 18'h3c001});
				check(slotLength, 0);
				send({3'h7, 1'b1, 36'hfffffffff});
				check(hdsShift, 0);
				send({3'h3, 1'b1, 4'h0, 14'h2a5c, 18'h3c001});
				check({slotLength, phaseOffset}, {14'h2a5c, 18'h3c001});
			end
			dph = rnd();
			// real mode keeps one word per sample, twice the pair rate
			send({3'h4, 1'b1, 3'h0, m == 1, m == 2, dph[23:0], 6'h37, m == 0});
			send({3'h5, 1'b1, 15'h000f, 16'h8000, 2'h0, 2'h0, 1'b1});
			send({3'h6, 2'h3, 6'h0, 3'h3, 2'h1, 2'h0, 2'h1, 1'b0, 2'h1, 1'b0, 2'h0, 1'b1, 13'h1});
			check({hdsShift, hdsPreload, deltaPhase}, {6'h37, 15'h000f, dph[23:0]});
			check({sineNegate, inputTwosComp}, {m == 0, 1'b1});
			exp.delete();
			rx.words.delete();
			for (k = 0; k < 8; k++) begin
				a = rnd();
				b = rnd();
				push(a[15:0], b[15:0]);
				if (m == 2) exp.push_back(k % 4 == 0 ? a[15:0] : k % 4 == 1 ? ng(b[15:0]) : k % 4 == 2 ? ng(a[15:0]) : b[15:0]);
				else begin
					exp.push_back(m == 1 && k % 2 ? ng(a[15:0]) : a[15:0]);
					exp.push_back(m == 1 && k % 2 ? ng(b[15:0]) : b[15:0]);
				end
			end
			sampleValid = 0;
			for (t = 0; t < 4000 && rx.words.size() < exp.size(); t++) @(posedge sys_clk);
			#1;
			check(rx.words.size(), exp.size());
			foreach (exp[j]) check(rx.words[j], exp[j]);
			check({iOe, qOe, bitClkOe, wordStrobeOe}, 4'hb);
			check(qOut, 1'b0);
			$display("test %0d done", m);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
